// >>> rtl/fault_check_parity_status.sv
// Fault and check reporting with parity diagnostic word and registers
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module fault_check_parity_status
  import fault_check_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Instruction flow
  input wire logic i_int_ovf,
  input wire logic i_div_zero,
  input wire logic i_dec_ovf,
  input wire logic i_ecc_correctable_check,
  input wire logic i_retire,
  input wire logic [PC_W-1:0] i_next_pc,
  // Other fault and check requests
  input wire logic i_fault_req,
  input wire logic [3:0] i_fault_type,
  input wire logic i_check_req,
  input wire logic [2:0] i_check_type,
  // Parity error reports
  input wire logic i_pa_type1,
  input wire logic i_pa_type2,
  input wire logic i_burst_err,
  input wire logic i_dma_err,
  input wire logic i_dma_out,
  input wire logic i_board_err,
  input wire logic [2:0] i_board_src,
  input wire logic i_ctlmem_err,
  input wire logic i_eccu_err,
  input wire logic i_pref_err,
  input wire logic i_paddr_err,
  input wire logic i_index_err,
  input wire logic i_eaddr_err,
  // Fault and check outputs
  output logic o_ovf_fault,
  output logic [PC_W-1:0] o_fault_pc,
  output logic o_fault,
  output logic [FAULT_W-1:0] o_fault_vec,
  output logic o_check,
  output logic [CHECK_W-1:0] o_check_vec,
  output logic [15:0] o_arith_fault_code_word,
  output logic o_irq
);
  typedef struct packed {
    logic [31:0] rdata;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic deep;
    logic [15:0] code;
    logic fault;
    logic [FAULT_W-1:0] fault_vec;
    logic check;
    logic [CHECK_W-1:0] check_vec;
  } top_regs_type;
  top_regs_type r;
  top_regs_type next_r;
  logic [31:0] parity_diagnostic_word;
  logic parity_ev;
  logic ovf_fault;
  logic [PC_W-1:0] fault_pc;
  logic par_clear;
  logic [FAULT_W-1:0] fsel;
  logic [CHECK_W-1:0] csel;
  logic [11:0] check_onehot;

  // One-hot decode shared by faults and checks
  function automatic logic [11:0] onehot(input logic [3:0] n);
    onehot = 12'h001 << n;
  endfunction

  assign par_clear = i_wr && (i_addr == OFF_PARITY);

  overflow_fault u_ovf (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_deep(r.deep),
    .i_int_ovf(i_int_ovf),
    .i_div_zero(i_div_zero),
    .i_ecc_corr(i_ecc_correctable_check),
    .i_retire(i_retire),
    .i_next_pc(i_next_pc),
    .o_fault(ovf_fault),
    .o_fault_pc(fault_pc)
  );

  parity_capture u_par (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pa_type1(i_pa_type1),
    .i_pa_type2(i_pa_type2),
    .i_burst_err(i_burst_err),
    .i_dma_err(i_dma_err),
    .i_dma_out(i_dma_out),
    .i_board_err(i_board_err),
    .i_board_src(i_board_src),
    .i_ctlmem_err(i_ctlmem_err),
    .i_eccu_err(i_eccu_err),
    .i_pref_err(i_pref_err),
    .i_paddr_err(i_paddr_err),
    .i_index_err(i_index_err),
    .i_eaddr_err(i_eaddr_err),
    .i_clear(par_clear),
    .o_word(parity_diagnostic_word),
    .o_event(parity_ev)
  );

  always_comb
  begin
    next_r = r;
    next_r.rdata = 32'h0000_0000;
    next_r.fault = 1'b0;
    next_r.check = 1'b0;
    fsel = onehot(i_fault_type) & FAULT_SUPPORTED;
    check_onehot = onehot({1'b0, i_check_type});
    csel = check_onehot[CHECK_W-1:0] & CHECK_SUPPORTED;
    // Semaphore and unknown codes are dropped
    if (i_fault_req && fsel != '0)
    begin
      next_r.fault = 1'b1;
      next_r.fault_vec = fsel;
    end
    // Environmental and recoverable machine checks never pass
    if (i_check_req && csel != '0)
    begin
      next_r.check = 1'b1;
      next_r.check_vec = csel;
    end
    if (i_dec_ovf)
      next_r.code = r.deep ? CODE_DEC_DEEP : CODE_DEC_BASE;
    if (i_wr)
    begin
      case (i_addr)
        OFF_STATUS:
          next_r.status = r.status & ~i_wdata[IRQ_W-1:0];
        OFF_MASK:
          next_r.mask = i_wdata[IRQ_W-1:0];
        OFF_CONFIG:
          next_r.deep = i_wdata[0];
        default:
          next_r.mask = next_r.mask;
      endcase
    end
    // Set wins over a simultaneous clear
    if (ovf_fault || next_r.fault)
      next_r.status[IRQ_FAULT] = 1'b1;
    if (next_r.check)
      next_r.status[IRQ_CHECK] = 1'b1;
    if (parity_ev)
      next_r.status[IRQ_PARITY] = 1'b1;
    if (i_rd)
    begin
      case (i_addr)
        OFF_PARITY:
          next_r.rdata = parity_diagnostic_word;
        OFF_STATUS:
          next_r.rdata = {{(32-IRQ_W){1'b0}}, r.status};
        OFF_MASK:
          next_r.rdata = {{(32-IRQ_W){1'b0}}, r.mask};
        OFF_CODE:
          next_r.rdata = {16'h0000, r.code};
        OFF_FAULT_PC:
          next_r.rdata = fault_pc;
        OFF_FAULT:
          next_r.rdata = {{(32-FAULT_W){1'b0}}, r.fault_vec};
        OFF_CHECK:
          next_r.rdata = {{(32-CHECK_W){1'b0}}, r.check_vec};
        OFF_CONFIG:
          next_r.rdata = {31'h0000_0000, r.deep};
        default:
          next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign o_rdata = r.rdata;
  assign o_ovf_fault = ovf_fault;
  assign o_fault_pc = fault_pc;
  assign o_fault = r.fault;
  assign o_fault_vec = r.fault_vec;
  assign o_check = r.check;
  assign o_check_vec = r.check_vec;
  assign o_arith_fault_code_word = r.code;
  assign o_irq = |(r.status & r.mask);
endmodule

// >>> rtl/fault_check_pkg.sv
// Constants and types shared by the fault and check reporting block
// Functional notes
// - Baseline: overflow fault taken before the next instruction starts.
// - Saved counter on overflow fault holds the next instruction address.
// - Correctable check pending with overflow discards the overflow.
// - Deep variant: two instructions complete before the fault.
// - Divide by zero always saves the next instruction address; the code drops it while a deep overflow waits in ST_WAIT.
// - Decimal overflow fault code is 704 baseline, 700 on deep variants.
// - Eleven fault types supported; semaphore faults are never raised.
// - Only power, memory parity, machine, missing module checks raised.
// - Status bit 1 marks type-1 program-address parity error on DMA paths.
// - Status bit 2 marks type-2 program-address parity error.
// - Status bit 3 marks parity error during burst-mode DMA.
// - Status bit 4 gives DMA error direction: 0 input, 1 output.
// - Status bits 5 to 7 encode the detected error source.
// - Status bit 8 flags control memory parity only if no board reported.
// - Status bit 9 marks memory ECC uncorrectable read error.
// - Status bit 10 marks prefetch board parity error.
// - Status bit 11 marks peripheral address bus input parity error.
// - Bit 12 index parity at last close; bit 14 address register parity.
package fault_check_pkg;
  localparam int ADDR_W = 4;
  localparam int PC_W = 32;
  // Register offsets
  localparam logic [3:0] OFF_PARITY = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_MASK = 4'h2;
  localparam logic [3:0] OFF_CODE = 4'h3;
  localparam logic [3:0] OFF_FAULT_PC = 4'h4;
  localparam logic [3:0] OFF_FAULT = 4'h5;
  localparam logic [3:0] OFF_CHECK = 4'h6;
  localparam logic [3:0] OFF_CONFIG = 4'h7;
  // Parity word bit positions; bit 1 is the most significant bit (31)
  localparam int PB_TYPE1 = 31;
  localparam int PB_TYPE2 = 30;
  localparam int PB_BURST = 29;
  localparam int PB_DIR = 28;
  localparam int PB_SRC_HI = 27;
  localparam int PB_SRC_LO = 25;
  localparam int PB_CTLMEM = 24;
  localparam int PB_ECCU = 23;
  localparam int PB_PREF = 22;
  localparam int PB_PADDR = 21;
  localparam int PB_INDEX = 20;
  localparam int PB_EADDR = 18;
  localparam logic [31:0] PARITY_RESET = 32'h0000_0000;
  // Decimal overflow codes
  localparam logic [15:0] CODE_DEC_BASE = 16'h0704;
  localparam logic [15:0] CODE_DEC_DEEP = 16'h0700;
  // Deep pipeline: instructions completing before the fault is taken
  localparam logic [2:0] DEEP_DELAY = 3'h2;
  // Interrupt status bit positions
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_CHECK = 1;
  localparam int IRQ_PARITY = 2;
  localparam int IRQ_W = 3;
  // Fault types (eleven supported, semaphore absent)
  localparam int FAULT_W = 12;
  localparam logic [3:0] FT_SEMAPHORE = 4'hb;
  localparam logic [11:0] FAULT_SUPPORTED = 12'h7ff;
  // Check types: power, parity, machine, missing module
  localparam int CHECK_W = 6;
  localparam logic [5:0] CHECK_SUPPORTED = 6'h0f;
  localparam int CK_PARITY = 1;
  localparam int CK_MACHINE = 2;
  typedef enum {ST_IDLE, ST_WAIT} ovf_state_type;
endpackage

// >>> rtl/overflow_fault.sv
// Integer overflow and divide-by-zero fault timing
`timescale 1ns/1ns
module overflow_fault
  import fault_check_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic i_deep,
  // Instruction events
  input wire logic i_int_ovf,
  input wire logic i_div_zero,
  input wire logic i_ecc_corr,
  input wire logic i_retire,
  input wire logic [PC_W-1:0] i_next_pc,
  // Fault request
  output logic o_fault,
  output logic [PC_W-1:0] o_fault_pc
);
  typedef struct packed {
    ovf_state_type st;
    logic [2:0] cnt;
    logic fault;
    logic [PC_W-1:0] pc;
  } ovf_regs_type;
  ovf_regs_type r;
  ovf_regs_type next_r;

  always_comb
  begin
    next_r = r;
    next_r.fault = 1'b0;
    case (r.st)
      ST_IDLE:
      begin
        if (i_div_zero)
        begin
          // Never deferred, even on the deep pipeline
          next_r.fault = 1'b1;
          next_r.pc = i_next_pc;
        end
        else if (i_int_ovf && !i_ecc_corr)
        begin
          if (i_deep)
          begin
            next_r.st = ST_WAIT;
            next_r.cnt = DEEP_DELAY;
          end
          else
          begin
            next_r.fault = 1'b1;
            next_r.pc = i_next_pc;
          end
        end
      end
      ST_WAIT:
      begin
        if (i_retire)
        begin
          next_r.cnt = r.cnt - 3'h1;
          if (r.cnt == 3'h1)
          begin
            next_r.st = ST_IDLE;
            next_r.fault = 1'b1;
            next_r.pc = i_next_pc;
          end
        end
      end
      default:
        next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      r <= '{st: ST_IDLE, cnt: 3'h0, fault: 1'b0, pc: '0};
    else
      r <= next_r;
  end

  assign o_fault = r.fault;
  assign o_fault_pc = r.pc;
endmodule

// >>> rtl/parity_capture.sv
// Capture of parity error causes into the diagnostic word
`timescale 1ns/1ns
module parity_capture
  import fault_check_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Error reports, one-cycle pulses
  input wire logic i_pa_type1,
  input wire logic i_pa_type2,
  input wire logic i_burst_err,
  input wire logic i_dma_err,
  input wire logic i_dma_out,
  input wire logic i_board_err,
  input wire logic [2:0] i_board_src,
  input wire logic i_ctlmem_err,
  input wire logic i_eccu_err,
  input wire logic i_pref_err,
  input wire logic i_paddr_err,
  input wire logic i_index_err,
  input wire logic i_eaddr_err,
  // Clear from software
  input wire logic i_clear,
  // Word and event
  output logic [31:0] o_word,
  output logic o_event
);
  typedef struct packed {
    logic [31:0] word;
    logic ev;
  } pc_regs_type;
  pc_regs_type r;
  pc_regs_type next_r;
  logic any;

  always_comb
  begin
    next_r = r;
    any = i_pa_type1 | i_pa_type2 | i_burst_err | i_dma_err | i_board_err |
      i_ctlmem_err | i_eccu_err | i_pref_err | i_paddr_err | i_index_err |
      i_eaddr_err;
    // A new error in the clearing cycle still lands
    if (i_clear)
      next_r.word = PARITY_RESET;
    if (i_pa_type1)
      next_r.word[PB_TYPE1] = 1'b1;
    if (i_pa_type2)
      next_r.word[PB_TYPE2] = 1'b1;
    if (i_burst_err)
      next_r.word[PB_BURST] = 1'b1;
    if (i_dma_err)
      next_r.word[PB_DIR] = i_dma_out;
    if (i_board_err)
      next_r.word[PB_SRC_HI:PB_SRC_LO] = i_board_src;
    if (i_ctlmem_err && !i_board_err &&
        next_r.word[PB_SRC_HI:PB_SRC_LO] == 3'h0 && !r.ev)
      next_r.word[PB_CTLMEM] = 1'b1;
    if (i_eccu_err)
      next_r.word[PB_ECCU] = 1'b1;
    if (i_pref_err)
      next_r.word[PB_PREF] = 1'b1;
    if (i_paddr_err)
      next_r.word[PB_PADDR] = 1'b1;
    if (i_index_err)
      next_r.word[PB_INDEX] = 1'b1;
    if (i_eaddr_err)
      next_r.word[PB_EADDR] = 1'b1;
    next_r.ev = any;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      r <= '{word: PARITY_RESET, ev: 1'b0};
    else
      r <= next_r;
  end

  assign o_word = r.word;
  assign o_event = r.ev;
endmodule

// >>> test/fault_check_parity_status_sva.sv
// Port-level assertions for the fault and parity status block
`timescale 1ns/1ns
module fault_check_parity_status_sva
  import fault_check_pkg::*;
(
  // Watched inputs
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_int_ovf,
  input wire logic i_div_zero,
  input wire logic i_dec_ovf,
  input wire logic i_ecc_correctable_check,
  input wire logic [PC_W-1:0] i_next_pc,
  input wire logic i_fault_req,
  input wire logic [3:0] i_fault_type,
  input wire logic i_check_req,
  input wire logic [2:0] i_check_type,
  // Watched outputs
  input wire logic [31:0] o_rdata,
  input wire logic o_ovf_fault,
  input wire logic [PC_W-1:0] o_fault_pc,
  input wire logic o_fault,
  input wire logic [FAULT_W-1:0] o_fault_vec,
  input wire logic o_check,
  input wire logic [CHECK_W-1:0] o_check_vec,
  input wire logic [15:0] o_arith_fault_code_word
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Shadow of the variant select, kept from the register writes
  logic deep;
  logic base_ovf;
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      deep <= 1'b0;
    else if (i_wr && i_addr == OFF_CONFIG)
      deep <= i_wdata[0];
  assign base_ovf = i_int_ovf && !i_ecc_correctable_check && !i_div_zero
    && !deep;
  chk_ovf_taken: assert property (base_ovf |=> o_ovf_fault)
    else $error("overflow fault not taken");
  chk_ovf_pc: assert property (base_ovf ##1 1'b1 |->
    o_fault_pc == $past(i_next_pc))
    else $error("overflow fault pc wrong");
  chk_ecc_drop: assert property (i_int_ovf && i_ecc_correctable_check
    && !i_div_zero && !deep |=> !o_ovf_fault)
    else $error("overflow not discarded");
  chk_div_pc: assert property (i_div_zero && !deep |=>
    o_ovf_fault && o_fault_pc == $past(i_next_pc))
    else $error("divide fault wrong");
  chk_dec_code: assert property (i_dec_ovf |=>
    o_arith_fault_code_word ==
    ($past(deep) ? CODE_DEC_DEEP : CODE_DEC_BASE))
    else $error("decimal code wrong");
  chk_fault_vec: assert property (i_fault_req &&
    i_fault_type < 4'hb |=>
    o_fault && o_fault_vec == 12'h001 << $past(i_fault_type))
    else $error("fault vector wrong");
  chk_sema_drop: assert property (i_fault_req && i_fault_type >= 4'hb
    && !i_int_ovf && !i_div_zero |=> !o_fault)
    else $error("unsupported fault raised");
  chk_check_kind: assert property (i_check_req |=>
    o_check == ($past(i_check_type) < 3'h4))
    else $error("check type handling wrong");
  chk_rd_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero");
  cover property (base_ovf);
  cover property (i_dec_ovf && deep);
  cover property (i_check_req && o_check_vec != 6'h00);
  cover property (o_ovf_fault && deep);
endmodule

bind fault_check_parity_status fault_check_parity_status_sva i_sva (.*);

// >>> test/fault_check_parity_status_test.sv
// Directed bench for the fault and parity status block
`timescale 1ns/1ns
module fault_check_parity_status_test;
  import fault_check_pkg::*;
  logic i_sys_clk, i_rst, i_wr, i_rd, i_dma_out, o_irq;
  logic [ADDR_W-1:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [PC_W-1:0] i_next_pc, o_fault_pc;
  logic [3:0] i_fault_type;
  logic [2:0] i_check_type, i_board_src;
  logic o_ovf_fault, o_fault, o_check;
  logic [FAULT_W-1:0] o_fault_vec;
  logic [CHECK_W-1:0] o_check_vec;
  logic [15:0] o_arith_fault_code_word;
  logic i_int_ovf, i_div_zero, i_dec_ovf, i_ecc_correctable_check;
  logic i_fault_req, i_check_req, i_pa_type1, i_pa_type2, i_burst_err;
  logic i_eccu_err, i_pref_err, i_paddr_err, i_index_err, i_eaddr_err;
  logic i_dma_err, i_board_err, i_ctlmem_err, i_retire;
  logic [17:0] ev;
  int fails, n_tests;
  int pbit[8] = '{1, 2, 3, 9, 10, 11, 12, 14};
  // All one-cycle event inputs travel as one vector of pulses
  assign {i_retire, i_ctlmem_err, i_board_err, i_dma_err, i_eaddr_err,
    i_index_err, i_paddr_err, i_pref_err, i_eccu_err, i_burst_err,
    i_pa_type2, i_pa_type1, i_check_req, i_fault_req,
    i_ecc_correctable_check, i_dec_ovf, i_div_zero, i_int_ovf} = ev;
  fault_check_parity_status i_fault_check_parity_status (.*);
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask
  // Outputs registered at the pulse's edge are settled on return
  task automatic pulse(input logic [17:0] v);
    @(posedge i_sys_clk);
    ev <= v;
    @(posedge i_sys_clk);
    ev <= '0;
    #1;
  endtask
  initial
  begin
    #200000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    {i_rst, i_wr, i_rd, i_dma_out, ev} = '1 << 21;
    {i_addr, i_wdata, i_next_pc, i_fault_type} = '0;
    {i_check_type, i_board_src} = '0;
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(OFF_PARITY, 32'h0);
    rd(4'hf, 32'h0);
    i_next_pc <= 32'h0000_1234;
    pulse(18'h00001);
    chk("ovf", 1, o_ovf_fault);
    chk("pc", 32'h1234, o_fault_pc);
    pulse(18'h00009);
    chk("ovf", 0, o_ovf_fault);
    i_next_pc <= 32'h0000_5678;
    pulse(18'h00002);
    chk("ovf", 1, o_ovf_fault);
    chk("pc", 32'h5678, o_fault_pc);
    rd(OFF_FAULT_PC, 32'h5678);
    pulse(18'h00004);
    chk("code", 32'h704, o_arith_fault_code_word);
    rd(OFF_CODE, 32'h704);
    for (int t = 0; t < 16; t++)
    begin
      i_fault_type <= t[3:0];
      pulse(18'h00010);
      chk("fault", t < 11, o_fault);
      if (t < 11)
        chk("fvec", 32'h1 << t, o_fault_vec);
    end
    rd(OFF_FAULT, 32'h400);
    for (int t = 0; t < 8; t++)
    begin
      i_check_type <= t[2:0];
      pulse(18'h00020);
      chk("check", t < 4, o_check);
      if (t < 4)
        chk("cvec", 32'h1 << t, o_check_vec);
    end
    rd(OFF_CHECK, 32'h8);
    for (int i = 0; i < 8; i++)
    begin
      pulse(18'h1 << (6 + i));
      rd(OFF_PARITY,
        32'h1 << (32 - pbit[i]));
      wr(OFF_PARITY, 32'h0);
    end
    for (int k = 0; k < 8; k++)
    begin
      i_board_src <= k[2:0];
      pulse(18'h08000);
      rd(OFF_PARITY, k << 25);
    end
    wr(OFF_PARITY, 32'h0);
    i_board_src <= 3'h2;
    pulse(18'h18000);
    rd(OFF_PARITY, 32'h2 << 25);
    wr(OFF_PARITY, 32'h0);
    pulse(18'h10000);
    rd(OFF_PARITY, 32'h1 << 24);
    wr(OFF_PARITY, 32'h0);
    i_dma_out <= 1'b1;
    pulse(18'h04000);
    rd(OFF_PARITY, 32'h1 << 28);
    i_dma_out <= 1'b0;
    pulse(18'h04000);
    rd(OFF_PARITY, 32'h0);
    wr(OFF_STATUS, 32'h7);
    wr(OFF_MASK, 32'h0);
    i_fault_type <= 4'h0;
    pulse(18'h00010);
    chk("irq", 0, o_irq);
    rd(OFF_STATUS, 32'h1);
    wr(OFF_MASK, 32'h1);
    #1 chk("irq", 1, o_irq);
    wr(OFF_STATUS, 32'h1);
    #1 chk("irq", 0, o_irq);
    i_check_type <= 3'h0;
    pulse(18'h00060);
    rd(OFF_STATUS, 32'h6);
    rd(OFF_MASK, 32'h1);
    wr(OFF_CONFIG, 32'h1);
    rd(OFF_CONFIG, 32'h1);
    pulse(18'h00004);
    chk("code", 32'h700, o_arith_fault_code_word);
    pulse(18'h00001);
    chk("ovf", 0, o_ovf_fault);
    pulse(18'h20000);
    chk("ovf", 0, o_ovf_fault);
    i_next_pc <= 32'h0000_9abc;
    pulse(18'h20000);
    chk("ovf", 1, o_ovf_fault);
    chk("pc", 32'h9abc, o_fault_pc);
    i_next_pc <= 32'h0000_def0;
    pulse(18'h00002);
    chk("ovf", 1, o_ovf_fault);
    chk("pc", 32'hdef0, o_fault_pc);
    // Reset in mid-run must bring every register back to zero
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1 chk("code", 32'h0, o_arith_fault_code_word);
    chk("pc", 32'h0, o_fault_pc);
    rd(OFF_CONFIG, 32'h0);
    rd(OFF_PARITY, 32'h0);
    report_and_stop();
  end
endmodule
